// >>> sreb_pkg.sv
// Purpose : Constants and types for the status event reporting bank
// Assumes : Six 16-bit status groups reached through a group/field command port
// Notes   : Bit 15 of every stored register is never kept
package sreb_pkg;

    // ==========================================================
    // Widths and group selection
    localparam int          SREB_W         = 16;
    localparam int          SREB_NGRP      = 6;
    localparam logic [2:0]  GRP_DEVICE     = 3'h0;
    localparam logic [2:0]  GRP_OPERATION  = 3'h1;
    localparam logic [2:0]  GRP_ZEROING    = 3'h2;
    localparam logic [2:0]  GRP_LOWER_FAIL = 3'h3;
    localparam logic [2:0]  GRP_SENSE      = 3'h4;
    localparam logic [2:0]  GRP_TRIGGER    = 3'h5;

    // ==========================================================
    // Register field selection within a group
    localparam logic [2:0]  FLD_CONDITION  = 3'h0;
    localparam logic [2:0]  FLD_EVENT      = 3'h1;
    localparam logic [2:0]  FLD_ENABLE     = 3'h2;
    localparam logic [2:0]  FLD_FALLING    = 3'h3;
    localparam logic [2:0]  FLD_RISING     = 3'h4;

    // ==========================================================
    // Preset values and masks
    localparam logic [15:0] RISING_PRESET  = 16'h7fff;
    localparam logic [15:0] CLEAR_PRESET   = 16'h0000;
    localparam logic [15:0] STORE_MASK     = 16'h7fff;

    // Used condition bits per group
    localparam logic [15:0] MASK_DEVICE    = 16'h001e;
    localparam logic [15:0] MASK_OPERATION = 16'h1c21;
    localparam logic [15:0] MASK_CHANNELS  = 16'h0006;
    localparam logic [15:0] MASK_LOWER     = 16'h0078;

    // Bit positions
    localparam int BIT_CH_A         = 1;
    localparam int BIT_CH_B         = 2;
    localparam int BIT_ERR_A        = 3;
    localparam int BIT_ERR_B        = 4;
    localparam int BIT_OP_ZEROING   = 0;
    localparam int BIT_OP_TRIGGER   = 5;
    localparam int BIT_OP_SENSE     = 10;
    localparam int BIT_OP_LOWER     = 11;
    localparam int BIT_OP_UPPER     = 12;
    localparam int BIT_WIN_FIRST    = 3;

    // Command port access state
    typedef enum logic [0:0] {
        SREB_IDLE = 1'b0,
        SREB_ANS  = 1'b1
    } sreb_phase_type;

endpackage

// >>> sreb_group_if.sv
// Purpose : Carries one group's control and result words between modules
// Assumes : Single clock domain
// Notes   : Owner modport holds the event registers; filter and enable registers are held by the bank
`timescale 1ns/1ps
interface sreb_group_if;
    import sreb_pkg::*;
    logic [15:0] condition;
    logic [15:0] rising_filter;
    logic [15:0] falling_filter;
    logic [15:0] enable;
    logic        read_event;
    logic        preset;
    logic [15:0] event_bits;
    logic        summary;

    modport owner (
        input  condition,
        input  rising_filter,
        input  falling_filter,
        input  enable,
        input  read_event,
        input  preset,
        output event_bits,
        output summary
    );
    modport bank (
        output condition,
        output rising_filter,
        output falling_filter,
        output enable,
        output read_event,
        output preset,
        input  event_bits,
        input  summary
    );
endinterface

// >>> sreb_group.sv
// Purpose : One status group: transition detect, sticky event, summary
// Assumes : Filters and enable arrive already masked to bit 14 and below
// Notes   : A new event in the read cycle survives the clear
`timescale 1ns/1ps
module sreb_group
    import sreb_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    sreb_group_if.owner gi
);

    typedef struct packed {
        logic [15:0] cond_prev;
        logic [15:0] events;
    } sreb_grp_state_type;

    sreb_grp_state_type st_q;
    sreb_grp_state_type st_d;
    logic [15:0]        rise;
    logic [15:0]        fall;
    logic [15:0]        hit;

    // ==========================================================
    // Edge detection and event latching
    always_comb
    begin
        rise = gi.condition & ~st_q.cond_prev;
        fall = ~gi.condition & st_q.cond_prev;
        hit  = ((rise & gi.rising_filter)          // [R5] [R7] [R8]
              | (fall & gi.falling_filter))        // [R6] [R7] [R8]
              & STORE_MASK;                        // [R25]
        st_d.cond_prev = gi.condition;
        if (gi.read_event)
            st_d.events = hit;                     // [R3]
        else
            st_d.events = st_q.events | hit;
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Summary toward the parent group
    assign gi.event_bits = st_q.events;
    assign gi.summary    = |(st_q.events & gi.enable);   // [R22] [R24]

endmodule

// >>> sreb_bank.sv
// Purpose : Status event reporting bank for a two-channel instrument
// Assumes : Commands arrive as group/field select with strobes, one clock
// Notes   : Read answer is registered, valid one cycle after the strobe
`timescale 1ns/1ps
// Behaviour
// R1: Condition reads give 0..32767 and leave the condition untouched.
// R2: Enable registers are read/write; bit 15 always reads zero.
// R3: Event read returns latched bits then clears the event register.
// R4: Falling and rising filters are read/write with bit 15 forced zero.
// R5: Rising condition with rising filter bit set sets the event bit.
// R6: Falling condition with falling filter bit set sets the event bit.
// R7: Both filters set: any condition change sets the event bit.
// R8: Both filters clear: condition changes never set the event bit.
// R9: Device bits 1,2 show sensor detected on channel A, B.
// R10: Device event bits 1,2 mean sensor connected or removed since read.
// R11: Falling filter bit on detect position reports sensor removal.
// R12: Rising filter bit on detect position reports sensor connection.
// R13: Device bits 3,4 show channel A, B sensor error.
// R14: Device bits 5,6 reserved; bit 0 and 7..14 unused.
// R15: Operation bit 0 zeroing summary, bit 5 trigger summary; others except bits 10..12 unused.
// R16: Operation bits 10,11,12: sense, lower-fail, upper-fail summaries.
// R17: Zeroing group bits 1,2 show channel A, B zeroing or zeroing_in_progress_group.
// R18: Lower-fail bits 3..6 flag each window measurement below its limit.
// R19: Sense group bits 1,2 show EEPROM read on channel A, B.
// R20: Trigger group bits 1,2 show channel A, B waiting for trigger.
// R21: Device event reaches status byte bit 1 only when enabled.
// R22: Zeroing event reaches operation bit 0 only when enabled.
// R23: Power-on or preset: rising filters 0x7fff, falling and enable cleared.
// R24: Summary bit is OR of child events and enables, parent's condition.
// R25: Unused and reserved bits of all registers read zero; filter and enable registers here keep any written bit 14..0.
module sreb_bank
    import sreb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        sensor_present_a,
    input  wire logic        sensor_present_b,
    input  wire logic        sensor_error_a,
    input  wire logic        sensor_error_b,
    input  wire logic        zeroing_a,
    input  wire logic        zeroing_b,
    input  wire logic [3:0]  lower_limit_fail,
    input  wire logic        upper_limit_fail_summary,
    input  wire logic        eeprom_read_a,
    input  wire logic        eeprom_read_b,
    input  wire logic        wait_trigger_a,
    input  wire logic        wait_trigger_b,
    input  wire logic        preset,
    input  wire logic [2:0]  cmd_group,
    input  wire logic [2:0]  cmd_field,
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_rvalid,
    output logic             cmd_error,
    output logic             device_summary
);

    // ==========================================================
    // Bank state: one packed struct
    typedef struct packed {
        logic [SREB_NGRP-1:0][15:0] rising;
        logic [SREB_NGRP-1:0][15:0] falling;
        logic [SREB_NGRP-1:0][15:0] enable;
        logic [15:0]                rdata;
        logic                       rerror;
        sreb_phase_type             phase;
    } sreb_bank_state_type;

    sreb_bank_state_type         st_q;
    sreb_bank_state_type         st_d;
    logic [SREB_NGRP-1:0][15:0]  cond;
    logic [SREB_NGRP-1:0][15:0]  evts;
    logic [SREB_NGRP-1:0]        summ;
    logic                        grp_ok;
    logic                        fld_ok;
    logic [15:0]                 wmask;
    logic [15:0]                 sel_cond;
    logic [15:0]                 sel_evt;
    logic [15:0]                 sel_en;
    logic [15:0]                 sel_fall;
    logic [15:0]                 sel_rise;

    // ==========================================================
    // Condition words from the measurement logic and child summaries
    always_comb
    begin
        cond = '0;
        cond[GRP_DEVICE][BIT_CH_A]       = sensor_present_a;           // [R9] [R10]
        cond[GRP_DEVICE][BIT_CH_B]       = sensor_present_b;           // [R9] [R10]
        cond[GRP_DEVICE][BIT_ERR_A]      = sensor_error_a;             // [R13]
        cond[GRP_DEVICE][BIT_ERR_B]      = sensor_error_b;             // [R13]
        cond[GRP_ZEROING][BIT_CH_A]      = zeroing_a;                  // [R17]
        cond[GRP_ZEROING][BIT_CH_B]      = zeroing_b;                  // [R17]
        cond[GRP_LOWER_FAIL][BIT_WIN_FIRST +: 4] = lower_limit_fail;   // [R18]
        cond[GRP_SENSE][BIT_CH_A]        = eeprom_read_a;              // [R19]
        cond[GRP_SENSE][BIT_CH_B]        = eeprom_read_b;              // [R19]
        cond[GRP_TRIGGER][BIT_CH_A]      = wait_trigger_a;             // [R20]
        cond[GRP_TRIGGER][BIT_CH_B]      = wait_trigger_b;             // [R20]
        cond[GRP_OPERATION][BIT_OP_ZEROING] = summ[GRP_ZEROING];       // [R15] [R24]
        cond[GRP_OPERATION][BIT_OP_TRIGGER] = summ[GRP_TRIGGER];       // [R15] [R24]
        cond[GRP_OPERATION][BIT_OP_SENSE]   = summ[GRP_SENSE];         // [R16] [R24]
        cond[GRP_OPERATION][BIT_OP_LOWER]   = summ[GRP_LOWER_FAIL];    // [R16] [R24]
        cond[GRP_OPERATION][BIT_OP_UPPER]   = upper_limit_fail_summary; // [R16]
        // Reserved device bits 5,6 and unused positions stay zero
        cond[GRP_DEVICE]     = cond[GRP_DEVICE] & MASK_DEVICE;         // [R14] [R25]
        cond[GRP_OPERATION]  = cond[GRP_OPERATION] & MASK_OPERATION;   // [R15] [R25]
        cond[GRP_ZEROING]    = cond[GRP_ZEROING] & MASK_CHANNELS;      // [R25]
        cond[GRP_LOWER_FAIL] = cond[GRP_LOWER_FAIL] & MASK_LOWER;      // [R25]
        cond[GRP_SENSE]      = cond[GRP_SENSE] & MASK_CHANNELS;        // [R25]
        cond[GRP_TRIGGER]    = cond[GRP_TRIGGER] & MASK_CHANNELS;      // [R25]
    end

    // ==========================================================
    // One group engine per status group
    genvar g;
    generate
        for (g = 0; g < SREB_NGRP; g++)
        begin : grp
            sreb_group_if gif ();
            assign gif.condition      = cond[g];
            assign gif.rising_filter  = st_q.rising[g];
            assign gif.falling_filter = st_q.falling[g];
            assign gif.enable         = st_q.enable[g];
            assign gif.preset         = preset;
            // Event read clears this group's events
            assign gif.read_event     = cmd_read && (cmd_group == 3'(g))
                                        && (cmd_field == FLD_EVENT);   // [R3]
            assign evts[g]            = gif.event_bits;
            assign summ[g]            = gif.summary;
            sreb_group u_group (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .gi      (gif.owner)
            );
        end
    endgenerate

    // ==========================================================
    // Command decode
    always_comb
    begin
        grp_ok   = (cmd_group < 3'(SREB_NGRP));
        fld_ok   = (cmd_field <= FLD_RISING);
        wmask    = STORE_MASK;
        sel_cond = '0;
        sel_evt  = '0;
        sel_en   = '0;
        sel_fall = '0;
        sel_rise = '0;
        if (grp_ok)
        begin
            sel_cond = cond[cmd_group];
            sel_evt  = evts[cmd_group];
            sel_en   = st_q.enable[cmd_group];
            sel_fall = st_q.falling[cmd_group];
            sel_rise = st_q.rising[cmd_group];
        end
    end

    // ==========================================================
    // Next state: writes, preset, registered read answer
    always_comb
    begin
        st_d        = st_q;
        st_d.phase  = SREB_IDLE;
        st_d.rerror = 1'b0;
        if (cmd_write && grp_ok)
        begin
            if (cmd_field == FLD_ENABLE)
                st_d.enable[cmd_group] = cmd_wdata & wmask;          // [R2]
            else if (cmd_field == FLD_FALLING)
                st_d.falling[cmd_group] = cmd_wdata & wmask;         // [R4] [R11]
            else if (cmd_field == FLD_RISING)
                st_d.rising[cmd_group] = cmd_wdata & wmask;          // [R4] [R12]
        end
        // Preset wins over a write in the same cycle
        if (preset)
        begin
            for (int i = 0; i < SREB_NGRP; i++)
            begin
                st_d.rising[i]  = RISING_PRESET;                     // [R23]
                st_d.falling[i] = CLEAR_PRESET;                      // [R23]
                st_d.enable[i]  = CLEAR_PRESET;                      // [R23]
            end
        end
        if (cmd_read)
        begin
            st_d.phase  = SREB_ANS;
            st_d.rerror = !(grp_ok && fld_ok);
            st_d.rdata  = '0;
            if (grp_ok)
            begin
                case (cmd_field)
                    FLD_CONDITION: st_d.rdata = sel_cond & STORE_MASK; // [R1]
                    FLD_EVENT:     st_d.rdata = sel_evt;               // [R3]
                    FLD_ENABLE:    st_d.rdata = sel_en;                // [R2]
                    FLD_FALLING:   st_d.rdata = sel_fall;              // [R4]
                    FLD_RISING:    st_d.rdata = sel_rise;              // [R4]
                    default:       st_d.rdata = '0;
                endcase
            end
        end
    end

    // State register; power-on values match the preset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < SREB_NGRP; i++)
            begin
                st_q.rising[i]  <= RISING_PRESET;                    // [R23]
                st_q.falling[i] <= CLEAR_PRESET;
                st_q.enable[i]  <= CLEAR_PRESET;
            end
            st_q.rdata  <= '0;
            st_q.rerror <= 1'b0;
            st_q.phase  <= SREB_IDLE;
        end
        else
            st_q <= st_d;
    end

    // ==========================================================
    // Outputs
    assign cmd_rdata      = st_q.rdata;
    assign cmd_rvalid     = (st_q.phase == SREB_ANS);
    assign cmd_error      = st_q.rerror;
    assign device_summary = summ[GRP_DEVICE];                        // [R21]

endmodule

// >>> sreb_bank_properties.sv
// Purpose : Port-level properties of the status event reporting bank
// Assumes : One clock domain, bound to every sreb_bank instance
// Notes   : Condition and event checks run only while level inputs sit still
`timescale 1ns/1ps
module sreb_bank_props
    import sreb_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        sensor_present_a,
    input wire logic        sensor_present_b,
    input wire logic        sensor_error_a,
    input wire logic        sensor_error_b,
    input wire logic        zeroing_a,
    input wire logic        zeroing_b,
    input wire logic [3:0]  lower_limit_fail,
    input wire logic        upper_limit_fail_summary,
    input wire logic        eeprom_read_a,
    input wire logic        eeprom_read_b,
    input wire logic        wait_trigger_a,
    input wire logic        wait_trigger_b,
    input wire logic        preset,
    input wire logic [2:0]  cmd_group,
    input wire logic [2:0]  cmd_field,
    input wire logic        cmd_write,
    input wire logic        cmd_read,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_rvalid,
    input wire logic        cmd_error,
    input wire logic        device_summary
);
    logic [14:0] in_all;
    logic [14:0] last_q;
    logic [2:0]  quiet_q;
    logic        up_q;
    logic [15:0] cond_exp;

    // ==========================================================
    // Helper logic
    // Level inputs gathered in one word
    assign in_all = {upper_limit_fail_summary, lower_limit_fail, sensor_present_a,
                     sensor_present_b, sensor_error_a, sensor_error_b, zeroing_a, zeroing_b,
                     eeprom_read_a, eeprom_read_b, wait_trigger_a, wait_trigger_b};

    // Counts cycles the level inputs have held still
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_q  <= 15'h0000;
            quiet_q <= 3'h0;
            up_q    <= 1'b0;
        end
        else
        begin
            last_q  <= in_all;
            quiet_q <= (in_all != last_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            up_q    <= 1'b1;
        end
    end

    // Condition word each non-summary group should show
    always_comb
    begin
        case (cmd_group)
            GRP_DEVICE:     cond_exp = {11'h000, sensor_error_b, sensor_error_a,
                                        sensor_present_b, sensor_present_a, 1'b0};
            GRP_ZEROING:    cond_exp = {13'h0000, zeroing_b, zeroing_a, 1'b0};
            GRP_LOWER_FAIL: cond_exp = {9'h000, lower_limit_fail, 3'h0};
            GRP_SENSE:      cond_exp = {13'h0000, eeprom_read_b, eeprom_read_a, 1'b0};
            default:        cond_exp = {13'h0000, wait_trigger_b, wait_trigger_a, 1'b0};
        endcase
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ev_rd;
        cmd_read && cmd_field == FLD_EVENT && cmd_group != GRP_OPERATION
            && cmd_group <= GRP_TRIGGER;
    endsequence
    sequence s_wr_ctl;
        cmd_write && !preset && cmd_field >= FLD_ENABLE && cmd_field <= FLD_RISING
            && cmd_group <= GRP_TRIGGER;
    endsequence
    sequence s_preset_rd;
        preset ##1 (!cmd_write && !preset) ##1
            (cmd_read && cmd_field == FLD_RISING && cmd_group <= GRP_TRIGGER);
    endsequence

    property p_read_answer;
        cmd_read |=> cmd_rvalid;
    endproperty
    property p_idle_quiet;
        !cmd_read |=> !cmd_rvalid && !cmd_error;
    endproperty
    property p_bad_read;
        cmd_read && (cmd_group > GRP_TRIGGER || cmd_field > FLD_RISING)
            |=> cmd_error && cmd_rdata == 16'h0000;
    endproperty
    property p_top_bit;
        cmd_rvalid |-> !cmd_rdata[15];
    endproperty
    property p_cond_read;
        cmd_read && cmd_field == FLD_CONDITION && cmd_group != GRP_OPERATION
            && cmd_group <= GRP_TRIGGER && up_q && $stable(in_all)
            |=> cmd_rdata == $past(cond_exp);
    endproperty
    property p_event_clear;
        s_ev_rd ##1 !cmd_read ##1 (s_ev_rd ##0 (cmd_group == $past(cmd_group, 2)
            && quiet_q >= 3'h4)) |=> cmd_rdata == 16'h0000;
    endproperty
    property p_write_back;
        s_wr_ctl ##1 (!cmd_write && !preset) ##1 (cmd_read
            && cmd_group == $past(cmd_group, 2) && cmd_field == $past(cmd_field, 2))
            |=> cmd_rdata == ($past(cmd_wdata, 3) & STORE_MASK);
    endproperty
    property p_preset_rising;
        s_preset_rd |=> cmd_rdata == RISING_PRESET;
    endproperty
    property p_preset_quiet;
        preset |=> !device_summary;
    endproperty

    a_read_answer: assert property (p_read_answer)
        else $error("read not answered one cycle later");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("answer without a read");
    a_bad_read: assert property (p_bad_read)
        else $error("bad address read not flagged");
    a_top_bit: assert property (p_top_bit)
        else $error("bit 15 of read data set");
    a_cond_read: assert property (p_cond_read)
        else $error("condition word does not follow inputs");
    a_event_clear: assert property (p_event_clear)
        else $error("event register not cleared by read");
    a_write_back: assert property (p_write_back)
        else $error("written value not read back");
    a_preset_rising: assert property (p_preset_rising)
        else $error("rising filter not preset");
    a_preset_quiet: assert property (p_preset_quiet)
        else $error("device summary set after preset");
endmodule

bind sreb_bank sreb_bank_props sreb_bank_props_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sensor_present_a(sensor_present_a),
    .sensor_present_b(sensor_present_b), .sensor_error_a(sensor_error_a),
    .sensor_error_b(sensor_error_b), .zeroing_a(zeroing_a), .zeroing_b(zeroing_b),
    .lower_limit_fail(lower_limit_fail), .upper_limit_fail_summary(upper_limit_fail_summary),
    .eeprom_read_a(eeprom_read_a), .eeprom_read_b(eeprom_read_b),
    .wait_trigger_a(wait_trigger_a), .wait_trigger_b(wait_trigger_b), .preset(preset),
    .cmd_group(cmd_group), .cmd_field(cmd_field), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_error(cmd_error), .device_summary(device_summary));

// >>> tb.sv
// Purpose : Self-checking bench for the status event reporting bank
// Assumes : 20 MHz clock, inputs driven 5 ns after the rising edge
// Notes   : Level inputs settle three cycles before any read
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb
    import sreb_pkg::*;
;
    logic        sys_clk, rst_n, preset, cmd_write, cmd_read, upper_limit_fail_summary;
    logic        sensor_present_a, sensor_present_b, sensor_error_a, sensor_error_b;
    logic        zeroing_a, zeroing_b, eeprom_read_a, eeprom_read_b;
    logic        wait_trigger_a, wait_trigger_b, cmd_rvalid, cmd_error, device_summary;
    logic [3:0]  lower_limit_fail;
    logic [2:0]  cmd_group, cmd_field;
    logic [15:0] cmd_wdata, cmd_rdata;
    int          n_mismatch, checks;

    sreb_bank sreb_bank_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .sensor_present_a(sensor_present_a),
        .sensor_present_b(sensor_present_b), .sensor_error_a(sensor_error_a),
        .sensor_error_b(sensor_error_b), .zeroing_a(zeroing_a), .zeroing_b(zeroing_b),
        .lower_limit_fail(lower_limit_fail), .upper_limit_fail_summary(upper_limit_fail_summary),
        .eeprom_read_a(eeprom_read_a), .eeprom_read_b(eeprom_read_b),
        .wait_trigger_a(wait_trigger_a), .wait_trigger_b(wait_trigger_b), .preset(preset),
        .cmd_group(cmd_group), .cmd_field(cmd_field), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .cmd_error(cmd_error), .device_summary(device_summary));

    // ==========================================================
    // Clock, watchdog and closing
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(2000 * 50);
        n_mismatch++;
        finish_test();
    end

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // Command port and level input tasks
    task automatic wr(input logic [2:0] g, input logic [2:0] f, input logic [15:0] d);
        @(posedge sys_clk);
        #5;
        {cmd_group, cmd_field, cmd_wdata, cmd_write} = {g, f, d, 1'b1};
        @(posedge sys_clk);
        #5;
        cmd_write = 1'b0;
    endtask

    task automatic rd(input logic [2:0] g, input logic [2:0] f, input logic [15:0] e,
                      input logic err = 1'b0);
        @(posedge sys_clk);
        #5;
        {cmd_group, cmd_field, cmd_read} = {g, f, 1'b1};
        @(posedge sys_clk);
        #5;
        cmd_read = 1'b0;
        `CHK({cmd_rvalid, cmd_error, cmd_rdata}, {1'b1, err, e})
    endtask

    // Order: upper, lower[3:0], present a b, error a b, zeroing a b, eeprom a b, trigger a b
    task automatic lv(input logic [14:0] v);
        @(posedge sys_clk);
        #5;
        {upper_limit_fail_summary, lower_limit_fail, sensor_present_a, sensor_present_b,
         sensor_error_a, sensor_error_b, zeroing_a, zeroing_b, eeprom_read_a,
         eeprom_read_b, wait_trigger_a, wait_trigger_b} = v;
        repeat (3) @(posedge sys_clk);
    endtask

    // ==========================================================
    // Test sequence
    initial
    begin
        {rst_n, preset, cmd_write, cmd_read, cmd_group, cmd_field, cmd_wdata} = '0;
        {upper_limit_fail_summary, lower_limit_fail, sensor_present_a, sensor_present_b,
         sensor_error_a, sensor_error_b, zeroing_a, zeroing_b, eeprom_read_a,
         eeprom_read_b, wait_trigger_a, wait_trigger_b} = '0;
        repeat (20) @(posedge sys_clk);
        #5;
        rst_n = 1'b1;
        for (int g = 0; g < SREB_NGRP; g++)
        begin
            rd(3'(g), FLD_RISING, RISING_PRESET);
            rd(3'(g), FLD_FALLING, CLEAR_PRESET);
            rd(3'(g), FLD_ENABLE, CLEAR_PRESET);
            rd(3'(g), FLD_CONDITION, 16'h0000);
            rd(3'(g), FLD_EVENT, 16'h0000);
        end
        wr(GRP_SENSE, FLD_ENABLE, 16'hffff);
        rd(GRP_SENSE, FLD_ENABLE, 16'h7fff);
        wr(GRP_OPERATION, FLD_FALLING, 16'hffff);
        rd(GRP_OPERATION, FLD_FALLING, 16'h7fff);
        wr(GRP_OPERATION, FLD_RISING, 16'h8001);
        rd(GRP_OPERATION, FLD_RISING, 16'h0001);
        wr(GRP_DEVICE, FLD_CONDITION, 16'h1234);
        rd(GRP_DEVICE, FLD_CONDITION, 16'h0000);
        rd(3'h7, FLD_EVENT, 16'h0000, 1'b1);
        rd(GRP_DEVICE, 3'h5, 16'h0000, 1'b1);
        // Device filters: bit 1 rising, bit 2 falling, bit 3 both, bit 4 neither
        wr(GRP_DEVICE, FLD_RISING, 16'h000a);
        wr(GRP_DEVICE, FLD_FALLING, 16'h000c);
        lv(15'h03c0);
        rd(GRP_DEVICE, FLD_CONDITION, 16'h001e);
        rd(GRP_DEVICE, FLD_EVENT, 16'h000a);
        rd(GRP_DEVICE, FLD_EVENT, 16'h0000);
        lv(15'h0000);
        rd(GRP_DEVICE, FLD_EVENT, 16'h000c);
        lv(15'h0200);
        wr(GRP_DEVICE, FLD_ENABLE, 16'h0004);
        `CHK(device_summary, 1'b0)
        wr(GRP_DEVICE, FLD_ENABLE, 16'h0002);
        `CHK(device_summary, 1'b1)
        // Child groups feed the operation summaries
        wr(GRP_ZEROING, FLD_ENABLE, 16'h0002);
        wr(GRP_SENSE, FLD_ENABLE, 16'h0002);
        wr(GRP_TRIGGER, FLD_ENABLE, 16'h0004);
        wr(GRP_LOWER_FAIL, FLD_ENABLE, 16'h0048);
        lv(15'h6429);
        rd(GRP_ZEROING, FLD_CONDITION, 16'h0002);
        rd(GRP_LOWER_FAIL, FLD_CONDITION, 16'h0048);
        rd(GRP_SENSE, FLD_CONDITION, 16'h0002);
        rd(GRP_TRIGGER, FLD_CONDITION, 16'h0004);
        rd(GRP_OPERATION, FLD_CONDITION, 16'h1c21);
        rd(GRP_ZEROING, FLD_EVENT, 16'h0002);
        rd(GRP_OPERATION, FLD_CONDITION, 16'h1c20);
        // Preset pulse restores filters and enables
        @(posedge sys_clk);
        #5;
        preset = 1'b1;
        @(posedge sys_clk);
        #5;
        preset = 1'b0;
        `CHK(device_summary, 1'b0)
        rd(GRP_DEVICE, FLD_RISING, RISING_PRESET);
        rd(GRP_DEVICE, FLD_FALLING, CLEAR_PRESET);
        rd(GRP_SENSE, FLD_ENABLE, CLEAR_PRESET);
        finish_test();
    end
endmodule
